// ==== design/pbs_sram_ctrl.sv ====
// Top of the pipelined burst SRAM: cycle decode, burst address, output register,
// and a small Avalon-MM register slave.
// Assumes the controller shares ref_clk, so pins are sampled by one register stage.
//
// What this block does
// R1 - Chip enable two, active high, blocks new cycles when low.
// R2 - Chip enable three, active low, blocks new cycles when high.
// R3 - All-byte write low writes all four lanes regardless of other writes.
// R4 - Systems using only lane writes hold all-byte write high.
// R5 - Write qualifier low writes only lanes whose lane write is low.
// R6 - Systems using only lane writes hold the write qualifier low.
// R7 - Write means qualifier plus any lane low, or all-byte write low.
// R8 - Enable one high with controller strobe low deselects, lanes high impedance.
// R9 - Enable one and processor strobe low with other enables off deselects.
// R10 - Processor strobe high, controller strobe low, enables off deselects.
// R11 - All enables on and processor strobe, or controller strobe without write, begins a read at external address.
// R12 - Controller-strobe start with write asserted begins external write.
// R13 - Strobes idle, step high, write asserted writes at held address.
// R14 - Strobes idle, step low on read advances to next burst address.
// R15 - Strobes idle, step low on write writes at next burst address.
// R16 - Strobes idle, step high on read holds current address.
// R17 - Write burst with strobes idle and step high suspends at current address.
// R18 - Output enable is not clocked; drivers follow it directly.
// R19 - Controller raises output enable before and through a write after read.
// R20 - Linear order counts low two bits upward, wrapping three to zero.
// R21 - Burst order pin low is linear, high interleaved, never registered.
// R22 - Enable one high ignores processor strobe, deselects on controller strobe.
// R23 - Output enable low drives data lanes only while registered read data is held, high leaves them undriven.
// R24 - Each advance sampled with strobes idle and not deselected steps the burst count in the selected order.
// R25 - Read data is registered and presented one edge after the access.
// R26 - Address, data and synchronous controls are registered on the rising edge.
`timescale 1ns/1ps
`include "pbs_cfg.svh"

module pbs_sram_ctrl (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic clkEn,
    // SRAM pins
    input wire logic [`PBS_ADDR_W-1:0] addr_in,
    input wire logic addr_strobe_proc_n,
    input wire logic addr_strobe_ctrl_n,
    input wire logic burst_step_n,
    input wire logic chip_en_n1,
    input wire logic chip_en_hi2,
    input wire logic chip_en_n3,
    input wire logic all_byte_write_n,
    input wire logic byte_write_qual_n,
    input wire logic [`PBS_LANES-1:0] lane_write_n,
    input wire logic burst_order_sel,
    input wire logic out_enable_n,
    input wire logic [`PBS_DATA_W-1:0] dataLanesIn,
    output logic [`PBS_DATA_W-1:0] dataLanesOut,
    output logic dataLanesOe,
    // Avalon-MM slave
    input wire logic [3:0] avsAddress,
    input wire logic avsRead,
    input wire logic avsWrite,
    input wire logic [31:0] avsWritedata,
    input wire logic [3:0] avsByteenable,
    output logic [31:0] avsReaddata,
    output logic avsWaitrequest
);

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic [`PBS_ADDR_W-1:0] addr;
        logic adspN;
        logic adscN;
        logic advN;
        logic ce1N;
        logic ce2;
        logic ce3N;
        logic abwN;
        logic bwqN;
        logic [`PBS_LANES-1:0] laneN;
        logic [`PBS_DATA_W-1:0] wdata;
        logic [`PBS_ADDR_W-3:0] highAddr;
        pbs_pkg::pbs_state_type state;
        logic [`PBS_DATA_W-1:0] outData;
        logic outValid;
        logic [31:0] ctrl;
        logic [31:0] rdCount;
        logic [31:0] wrCount;
        logic [31:0] rdata;
        logic waitReq;
    } pbs_top_type;

    pbs_top_type s_q;
    pbs_top_type s_d;

    pbs_pkg::pbs_cycle_type cycle;
    logic sel23;
    logic isWrite;
    logic [`PBS_LANES-1:0] laneSel;
    logic [`PBS_LANES-1:0] wrLanes;
    logic load;
    logic step;
    logic [1:0] useLow;
    logic [`PBS_ADDR_W-1:0] accAddr;
    logic [`PBS_DATA_W-1:0] rdData;
    logic access;
    logic wrCycle;
    logic rdAccess;
    logic busDone;
    logic [31:0] regVal;

    // ****************************************
    // Cycle decode on the registered pins
    // ****************************************
    always_comb begin
        sel23 = s_q.ce2 && !s_q.ce3N; // see R1, see R2
        laneSel = '0;
        if (!s_q.abwN) begin
            laneSel = '1; // see R3
        end else if (!s_q.bwqN) begin
            laneSel = ~s_q.laneN; // see R5
        end
        isWrite = (laneSel != '0); // see R7
        cycle = pbs_pkg::CYC_NONE;
        if (s_q.ce1N && !s_q.adscN) begin
            cycle = pbs_pkg::CYC_DESELECT; // see R8, see R22
        end else if (!s_q.ce1N && !s_q.adspN) begin
            if (sel23) begin
                cycle = pbs_pkg::CYC_BEGIN_EXT; // see R11
            end else begin
                cycle = pbs_pkg::CYC_DESELECT; // see R9
            end
        end else if (!s_q.adscN) begin
            if (sel23) begin
                cycle = pbs_pkg::CYC_BEGIN_EXT; // see R11, see R12
            end else begin
                cycle = pbs_pkg::CYC_DESELECT; // see R10
            end
        end else if (s_q.state != pbs_pkg::ST_DESELECTED) begin
            if (!s_q.advN) begin
                cycle = pbs_pkg::CYC_CONTINUE; // see R14, see R15
            end else begin
                cycle = pbs_pkg::CYC_SUSPEND; // see R13, see R16, see R17
            end
        end
    end

    // ****************************************
    // Access kind and write lanes
    // ****************************************
    always_comb begin
        load = (cycle == pbs_pkg::CYC_BEGIN_EXT);
        step = (cycle == pbs_pkg::CYC_CONTINUE); // see R24
        access = load || step || (cycle == pbs_pkg::CYC_SUSPEND);
        // Processor-strobe starts are always reads
        wrCycle = isWrite && !(load && !s_q.adspN); // see R7
        rdAccess = access && !wrCycle; // see R25
        wrLanes = '0;
        if (access && wrCycle && !s_q.ctrl[`PBS_CTRL_WPROT_BIT]) begin
            wrLanes = laneSel; // see R12, see R13, see R15
        end
    end

    pbs_burst_count u_burst (
        .ref_clk(ref_clk),
        .rst(rst),
        .clkEn(clkEn),
        .load(load),
        .step(step),
        .startLow(s_q.addr[1:0]),
        .orderSel(burst_order_sel),
        .useLow(useLow)
    );

    always_comb begin
        if (load) begin
            accAddr = s_q.addr;
        end else begin
            accAddr = {s_q.highAddr, useLow}; // see R14, see R16
        end
    end

    pbs_mem_array u_mem (
        .ref_clk(ref_clk),
        .clkEn(clkEn),
        .wrLanes(wrLanes),
        .addr(accAddr),
        .wrData(s_q.wdata),
        .rdData(rdData)
    );

    // ****************************************
    // Register slave decode
    // ****************************************
    always_comb begin
        case (avsAddress)
            `PBS_OFS_CTRL: regVal = s_q.ctrl;
            `PBS_OFS_STATUS: begin
                regVal = '0;
                regVal[`PBS_STAT_STATE_MSB:`PBS_STAT_STATE_LSB] = s_q.state;
                regVal[`PBS_STAT_LOW_MSB:`PBS_STAT_LOW_LSB] = accAddr[1:0];
                regVal[`PBS_STAT_ORDER_BIT] = burst_order_sel;
            end
            `PBS_OFS_RDCOUNT: regVal = s_q.rdCount;
            `PBS_OFS_WRCOUNT: regVal = s_q.wrCount;
            default: regVal = '0;
        endcase
        busDone = (avsRead || avsWrite) && !s_q.waitReq;
    end

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        s_d = s_q;
        s_d.addr = addr_in; // see R26
        s_d.adspN = addr_strobe_proc_n;
        s_d.adscN = addr_strobe_ctrl_n;
        s_d.advN = burst_step_n;
        s_d.ce1N = chip_en_n1;
        s_d.ce2 = chip_en_hi2;
        s_d.ce3N = chip_en_n3;
        s_d.abwN = all_byte_write_n;
        s_d.bwqN = byte_write_qual_n;
        s_d.laneN = lane_write_n;
        s_d.wdata = dataLanesIn;
        if (load) begin
            s_d.highAddr = s_q.addr[`PBS_ADDR_W-1:2];
        end
        case (cycle)
            pbs_pkg::CYC_DESELECT: s_d.state = pbs_pkg::ST_DESELECTED;
            pbs_pkg::CYC_BEGIN_EXT: begin
                if (isWrite && s_q.adspN) begin
                    s_d.state = pbs_pkg::ST_WRITING;
                end else begin
                    s_d.state = pbs_pkg::ST_READING;
                end
            end
            pbs_pkg::CYC_CONTINUE, pbs_pkg::CYC_SUSPEND: begin
                if (isWrite) begin
                    s_d.state = pbs_pkg::ST_WRITING;
                end else begin
                    s_d.state = pbs_pkg::ST_READING;
                end
            end
            default: s_d.state = s_q.state;
        endcase
        // Output register holds read data for the next cycle
        s_d.outValid = 1'b0;
        if (rdAccess) begin
            s_d.outData = rdData; // see R25
            s_d.outValid = 1'b1;
        end
        // ****************************************
        // Access counters
        // ****************************************
        if (access && !rdAccess) begin
            s_d.wrCount = 32'(s_q.wrCount + 32'h1);
        end else if (rdAccess) begin
            s_d.rdCount = 32'(s_q.rdCount + 32'h1);
        end
        // ****************************************
        // Register slave: one wait cycle, then answer
        // ****************************************
        s_d.waitReq = !((avsRead || avsWrite) && s_q.waitReq);
        if ((avsRead || avsWrite) && s_q.waitReq) begin
            s_d.rdata = avsRead ? regVal : 32'h0;
        end
        if (busDone && avsWrite && avsAddress == `PBS_OFS_CTRL) begin
            for (int b = 0; b < 4; b++) begin
                if (avsByteenable[b]) begin
                    s_d.ctrl[b*8 +: 8] = avsWritedata[b*8 +: 8];
                end
            end
            s_d.ctrl[31:1] = '0;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s_q <= '0;
            s_q.adspN <= 1'b1;
            s_q.adscN <= 1'b1;
            s_q.advN <= 1'b1;
            s_q.ce1N <= 1'b1;
            s_q.ce3N <= 1'b1;
            s_q.abwN <= 1'b1;
            s_q.bwqN <= 1'b1;
            s_q.laneN <= '1;
            s_q.ctrl <= `PBS_CTRL_RESET;
            s_q.rdCount <= `PBS_COUNT_RESET;
            s_q.wrCount <= `PBS_COUNT_RESET;
            s_q.rdata <= `PBS_RDATA_RESET;
            s_q.waitReq <= 1'b1;
            s_q.state <= pbs_pkg::ST_DESELECTED;
        end else if (clkEn) begin
            s_q <= s_d;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign dataLanesOut = s_q.outData;
    assign dataLanesOe = s_q.outValid && !out_enable_n; // see R18, see R23
    assign avsReaddata = s_q.rdata;
    assign avsWaitrequest = s_q.waitReq;

endmodule

// ==== design/pbs_cfg.svh ====
// Constants of the pipelined burst SRAM cycle control: offsets, fields, resets.
// Assumes inclusion by bare name from the design files of this block.
`ifndef PBS_CFG_SVH
`define PBS_CFG_SVH

// ****************************************
// Array geometry
// ****************************************
`define PBS_ADDR_W 15
`define PBS_DATA_W 36
`define PBS_LANES 4
`define PBS_LANE_W 9
`define PBS_DEPTH 32768

// ****************************************
// Register byte offsets on the Avalon-MM slave
// ****************************************
`define PBS_OFS_CTRL 4'h0
`define PBS_OFS_STATUS 4'h4
`define PBS_OFS_RDCOUNT 4'h8
`define PBS_OFS_WRCOUNT 4'hc

// ****************************************
// Field positions
// ****************************************
`define PBS_CTRL_WPROT_BIT 0
`define PBS_STAT_STATE_LSB 0
`define PBS_STAT_STATE_MSB 1
`define PBS_STAT_LOW_LSB 2
`define PBS_STAT_LOW_MSB 3
`define PBS_STAT_ORDER_BIT 4

// ****************************************
// Reset values
// ****************************************
`define PBS_CTRL_RESET 32'h0000_0000
`define PBS_COUNT_RESET 32'h0000_0000
`define PBS_RDATA_RESET 32'h0000_0000

`endif

// ==== design/pbs_pkg.sv ====
// Types shared by the pipelined burst SRAM cycle control.
// Assumes the constants of pbs_cfg.svh.
`include "pbs_cfg.svh"

package pbs_pkg;

    // ****************************************
    // Access state of the array
    // ****************************************
    typedef enum logic [1:0] {
        ST_DESELECTED,
        ST_READING,
        ST_WRITING
    } pbs_state_type;

    // ****************************************
    // Decoded kind of the current cycle
    // ****************************************
    typedef enum logic [2:0] {
        CYC_DESELECT,
        CYC_BEGIN_EXT,
        CYC_CONTINUE,
        CYC_SUSPEND,
        CYC_NONE
    } pbs_cycle_type;

endpackage

// ==== design/pbs_burst_count.sv ====
// Two-bit burst address counter with linear or interleaved order.
// Assumes load and step come from registered controls on the same clock.
`timescale 1ns/1ps
`include "pbs_cfg.svh"

module pbs_burst_count (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic clkEn,
    input wire logic load,
    input wire logic step,
    input wire logic [1:0] startLow,
    input wire logic orderSel,
    output logic [1:0] useLow
);

    typedef struct packed {
        logic [1:0] start;
        logic [1:0] count;
    } pbs_burst_type;

    pbs_burst_type s_q;
    pbs_burst_type s_d;
    logic [1:0] cnt;
    logic [1:0] base;

    // ****************************************
    // Address used this cycle
    // ****************************************
    always_comb begin
        s_d = s_q;
        base = s_q.start;
        cnt = s_q.count;
        if (load) begin
            base = startLow;
            cnt = 2'h0;
        end else if (step) begin
            cnt = 2'(s_q.count + 2'h1); // see R24
        end
        s_d.start = base;
        s_d.count = cnt;
        if (orderSel) begin
            useLow = base ^ cnt; // see R21
        end else begin
            useLow = 2'(base + cnt); // see R20
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s_q <= '0;
        end else if (clkEn) begin
            s_q <= s_d;
        end
    end

endmodule

// ==== design/pbs_mem_array.sv ====
// Storage array of 32K words in four nine-bit byte lanes.
// Assumes write lanes, address and data are registered by the caller.
`timescale 1ns/1ps
`include "pbs_cfg.svh"

module pbs_mem_array (
    input wire logic ref_clk,
    input wire logic clkEn,
    input wire logic [`PBS_LANES-1:0] wrLanes,
    input wire logic [`PBS_ADDR_W-1:0] addr,
    input wire logic [`PBS_DATA_W-1:0] wrData,
    output logic [`PBS_DATA_W-1:0] rdData
);

    // ****************************************
    // Per-lane storage, read and write
    // ****************************************
    generate
        for (genvar i = 0; i < `PBS_LANES; i++) begin : g_lane
            logic [`PBS_LANE_W-1:0] lane_q [`PBS_DEPTH];
            assign rdData[i*`PBS_LANE_W +: `PBS_LANE_W] = lane_q[addr];
            always_ff @(posedge ref_clk) begin
                if (clkEn && wrLanes[i]) begin
                    lane_q[addr] <= wrData[i*`PBS_LANE_W +: `PBS_LANE_W];
                end
            end
        end
    endgenerate

endmodule

// ==== testbench/pbs_sram_ctrl_monitor.sv ====
// Checker of the burst SRAM cycle control, watching its top ports only.
// Assumes a single clock domain; checks pause while clkEn is low.
`timescale 1ns/1ps

module pbs_sram_ctrl_monitor (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic clkEn,
    input wire logic addr_strobe_proc_n,
    input wire logic addr_strobe_ctrl_n,
    input wire logic burst_step_n,
    input wire logic chip_en_n1,
    input wire logic chip_en_hi2,
    input wire logic chip_en_n3,
    input wire logic all_byte_write_n,
    input wire logic byte_write_qual_n,
    input wire logic [3:0] lane_write_n,
    input wire logic out_enable_n,
    input wire logic dataLanesOe,
    input wire logic avsRead,
    input wire logic avsWrite,
    input wire logic avsWaitrequest
);
    logic wr;
    logic en;
    logic idle;
    assign wr = !all_byte_write_n || (!byte_write_qual_n && lane_write_n != 4'hf);
    assign en = !chip_en_n1 && chip_en_hi2 && !chip_en_n3;
    assign idle = (addr_strobe_proc_n || chip_en_n1) && addr_strobe_ctrl_n;
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst || !clkEn);

    // ****************************************
    // Assertions
    // ****************************************
    AST_OE_FOLLOWS: assert property (dataLanesOe |-> !out_enable_n)
        else $error("data lanes driven while output enable is high");
    AST_DESEL_ONE: assert property (
            chip_en_n1 && !addr_strobe_ctrl_n |-> ##2 !dataLanesOe)
        else $error("enable one deselect still drives");
    AST_DESEL_PROC: assert property (
            !chip_en_n1 && !addr_strobe_proc_n && (chip_en_n3 || !chip_en_hi2)
            |-> ##2 !dataLanesOe)
        else $error("processor strobe deselect still drives");
    AST_DESEL_CTRL: assert property (
            addr_strobe_proc_n && !addr_strobe_ctrl_n && (chip_en_n3 || !chip_en_hi2)
            |-> ##2 !dataLanesOe)
        else $error("controller strobe deselect still drives");
    AST_READ_BEGIN: assert property (
            en && (!addr_strobe_proc_n || !addr_strobe_ctrl_n && !wr)
            |-> ##2 (dataLanesOe || out_enable_n))
        else $error("begun read gives no data two edges later");
    AST_WRITE_BEGIN: assert property (
            en && addr_strobe_proc_n && !addr_strobe_ctrl_n && wr |-> ##2 !dataLanesOe)
        else $error("begun write drives the data lanes");
    AST_WRITE_CONT: assert property (idle && wr |-> ##2 !dataLanesOe)
        else $error("continued write drives the data lanes");
    AST_READ_CONT: assert property (en && !addr_strobe_proc_n ##1 idle && !wr
            |-> ##2 (dataLanesOe || out_enable_n))
        else $error("continued read gives no data");
    AST_WAIT_ONE: assert property (!avsWaitrequest |=> avsWaitrequest)
        else $error("waitrequest low longer than one cycle");
    AST_WAIT_ANSWER: assert property ((avsRead || avsWrite) && avsWaitrequest |=> !avsWaitrequest)
        else $error("bus request not answered next cycle");
    COV_READ_BURST: cover property (en && !addr_strobe_proc_n ##1 idle && !burst_step_n);
    COV_WRITE_BEGIN: cover property (en && !addr_strobe_ctrl_n && wr);
    COV_DESELECT: cover property (chip_en_n1 && !addr_strobe_ctrl_n);
    COV_BUS_READ: cover property (avsRead && !avsWaitrequest);
endmodule

bind pbs_sram_ctrl pbs_sram_ctrl_monitor mon (.ref_clk, .rst, .clkEn, .addr_strobe_proc_n,
    .addr_strobe_ctrl_n, .burst_step_n, .chip_en_n1, .chip_en_hi2, .chip_en_n3,
    .all_byte_write_n, .byte_write_qual_n, .lane_write_n, .out_enable_n, .dataLanesOe,
    .avsRead, .avsWrite, .avsWaitrequest);

// ==== testbench/pbs_cpu_model.sv ====
// Cache controller model driving the burst SRAM pins one cycle per call.
// Assumes pins() is called right after a rising edge of ref_clk.
`timescale 1ns/1ps

module pbs_cpu_model (
    input wire logic ref_clk,
    output logic [5:0] ctl,
    output logic [5:0] wrc,
    output logic [14:0] addr,
    output logic [35:0] data,
    output logic outEnN
);
    logic [2:0] wrHist;
    initial begin
        ctl = 6'h3f;
        wrc = 6'h2f;
        addr = 15'h0;
        data = 36'h0;
        outEnN = 1'b1;
        wrHist = 3'h0;
    end

    // ****************************************
    // One pin cycle: enables, strobes, writes
    // ****************************************
    task automatic pins(input logic [5:0] c, input logic [5:0] w, input logic [14:0] a,
            input logic [35:0] d);
        logic wr;
        wr = !w[5] || (!w[4] && w[3:0] != 4'hf);
        wrHist = {wrHist[1:0], wr};
        ctl <= c;
        wrc <= w;
        addr <= a;
        data <= wr ? d : ~data;
        outEnN <= |wrHist;
        @(posedge ref_clk);
    endtask
endmodule

// ==== testbench/pbs_sram_ctrl_test.sv ====
// Self-checking bench of the burst SRAM cycle control.
// Assumes the partner model drives the SRAM pins and the bench the Avalon slave.
`timescale 1ns/1ps

module pbs_sram_ctrl_test;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic order = 1'b0;
    logic [5:0] ctl;
    logic [5:0] wrc;
    logic [14:0] addr;
    logic [35:0] data;
    logic outEnN;
    logic [35:0] dataLanesOut;
    logic dataLanesOe;
    logic [3:0] avsAddress = 4'h0;
    logic avsRead = 1'b0;
    logic avsWrite = 1'b0;
    logic [31:0] avsWritedata = 32'h0;
    logic [31:0] avsReaddata;
    logic avsWaitrequest;
    logic [31:0] seed = 32'h15bd7b78;
    logic [35:0] mem [int];
    logic [14:0] base = 15'h0;
    logic [1:0] k = 2'h0;
    logic act = 1'b0;
    logic [36:0] e0 = 37'h0;
    logic [36:0] e1 = 37'h0;
    logic [36:0] e2 = 37'h0;
    logic [5:0] dsel [5] = '{6'h35, 6'h1b, 6'h03, 6'h1d, 6'h05};
    int mismatches = 0;
    int checksDone = 0;
    int rdExp = 0;
    int wrExp = 0;
    logic wprot = 1'b0;
    logic frz = 1'b0;
    logic clkEn = 1'b1;

    always #2.5 ref_clk = ~ref_clk;

    pbs_cpu_model model (.ref_clk(ref_clk), .ctl(ctl), .wrc(wrc), .addr(addr), .data(data),
        .outEnN(outEnN));

    pbs_sram_ctrl DUT (.ref_clk(ref_clk), .rst(rst), .clkEn(clkEn), .addr_in(addr),
        .addr_strobe_proc_n(ctl[2]), .addr_strobe_ctrl_n(ctl[1]), .burst_step_n(ctl[0]),
        .chip_en_n1(ctl[5]), .chip_en_hi2(ctl[4]), .chip_en_n3(ctl[3]),
        .all_byte_write_n(wrc[5]), .byte_write_qual_n(wrc[4]), .lane_write_n(wrc[3:0]),
        .burst_order_sel(order), .out_enable_n(outEnN), .dataLanesIn(data),
        .dataLanesOut(dataLanesOut), .dataLanesOe(dataLanesOe), .avsAddress(avsAddress),
        .avsRead(avsRead), .avsWrite(avsWrite), .avsWritedata(avsWritedata),
        .avsByteenable(4'hf), .avsReaddata(avsReaddata), .avsWaitrequest(avsWaitrequest));

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [31:0] rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed;
    endfunction

    task automatic check(input logic [35:0] got, input logic [35:0] exp);
        checksDone++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", checksDone, mismatches);
        if (mismatches == 0 && checksDone > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Drives one pin cycle and predicts its access
    task automatic op(input logic [5:0] c, input logic [5:0] w, input logic [14:0] a);
        logic wr;
        logic acc;
        logic [14:0] at;
        logic [35:0] d;
        d = {seed[3:0], rnd()};
        wr = !w[5] || (!w[4] && w[3:0] != 4'hf);
        acc = 1'b0;
        if (!frz && ((!c[5] && !c[2]) || !c[1])) begin
            act = !c[5] && c[4] && !c[3];
            base = a;
            k = 2'h0;
            acc = act;
        end else if (!frz && act) begin
            k = k + 2'(!c[0]);
            acc = 1'b1;
        end
        rdExp += int'(acc && !wr);
        wrExp += int'(acc && wr);
        at = {base[14:2], order ? base[1:0] ^ k : base[1:0] + k};
        for (int i = 0; i < 4; i++) begin
            if (acc && wr && !wprot && (!w[5] || (!w[4] && !w[i]))) begin
                mem[at][9*i+:9] = d[9*i+:9];
            end
        end
        e0 <= {acc && !wr, (acc && !wr) ? mem[at] : 36'h0};
        model.pins(c, w, a, d);
    endtask

    task automatic avs(input logic wr, input logic [3:0] a, input logic [31:0] wd,
            output logic [31:0] rd);
        avsAddress <= a;
        avsWrite <= wr;
        avsRead <= !wr;
        avsWritedata <= wd;
        do @(posedge ref_clk); while (avsWaitrequest !== 1'b0);
        rd = avsReaddata;
        avsRead <= 1'b0;
        avsWrite <= 1'b0;
        @(posedge ref_clk);
    endtask

    always @(posedge ref_clk) begin
        e1 <= e0;
        e2 <= e1;
    end

    always @(negedge ref_clk) begin
        if (!rst) begin
            check(36'(dataLanesOe), 36'(e2[36] && !outEnN));
            if (e2[36]) check(dataLanesOut, e2[35:0]);
        end
    end

    // ****************************************
    // Scenarios
    // ****************************************
    initial begin
        logic [14:0] a;
        logic [31:0] rd;
        repeat (5) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        for (int o = 0; o < 2; o++) begin
            order <= o[0];
            @(posedge ref_clk);
            repeat (4) begin
                a = 15'(rnd());
                op(6'h15, 6'h20, a);
                op(6'h16, 6'h20, a);
                op(6'h17, 6'h20, a);
                op(6'h16, 6'h1f, a);
                op(6'h16, 6'h20, a);
                op(6'h13, 6'h3f, a);
                op(6'h16, 6'h2f, a);
                op(6'h17, 6'h3f, a);
                op(6'h32, 6'h3f, a);
                op(6'h16, 6'h3f, a);
                op(6'h15, {2'h2, seed[3:0]}, a);
                op(6'h15, {2'h1, seed[7:4]}, a);
                op(6'h15, 6'h3f, a);
                foreach (dsel[i]) op(dsel[i], 6'h1f, 15'(rnd()));
                op(6'h16, 6'h20, a);
                op(6'h15, 6'h3f, a);
            end
            op(6'h35, 6'h3f, a);
            $display("burst test with order %0d done", o);
        end
        avs(1'b1, 4'h0, 32'hffffffff, rd);
        avs(1'b1, 4'h1, 32'h0, rd);
        avs(1'b0, 4'h0, 32'h0, rd);
        check(36'(rd), 36'h1);
        avs(1'b0, 4'h4, 32'h0, rd);
        check(36'(rd[4]), 36'(order));
        check(36'(rd[1:0]), 36'h0);
        wprot = 1'b1;
        op(6'h15, 6'h20, a);
        op(6'h15, 6'h3f, a);
        repeat (2) op(6'h35, 6'h3f, a);
        frz = 1'b1;
        clkEn <= 1'b0;
        op(6'h15, 6'h20, a);
        op(6'h15, 6'h3f, a);
        frz = 1'b0;
        clkEn <= 1'b1;
        op(6'h35, 6'h3f, a);
        avs(1'b0, 4'h8, 32'h0, rd);
        check(36'(rd), 36'(rdExp));
        avs(1'b0, 4'hc, 32'h0, rd);
        check(36'(rd), 36'(wrExp));
        $display("register test done");
        summarize();
    end

    initial begin
        repeat (3000) @(posedge ref_clk);
        mismatches++;
        summarize();
    end
endmodule
